// *** pkg/supervisor_defines.vh ***
// constants for the supply supervisor and watchdog
// Functional notes
// R1: warning output goes low when supply reaches the warning threshold.
// R2: active-low reset held while the supply-below-trip flag is true.
// R3: reset stays asserted 200ms after supply recovers.
// R4: watchdog expiry asserts reset for 200ms from expiry.
// R5: kick input must toggle within 1.6sec or reset asserts.
// R6: floating kick input disables the watchdog completely.
// R7: active-high reset is always the inverse of the active-low one.
// R8: disabled chip-select gate forces the gated output high.
// R9: backup cell feeds RAM only when below trip and below cell level.
// R10: kick edges clear the watchdog count; reset holds it cleared.
// R11: stretch timer restarts if supply dips again during stretch.
// R12: active chip-select at reset keeps gate open up to 18us.
// R13: forced-high chip-select stays high until reset off and input low.
// R14: intervals come from counting clock cycles, lengths set by parameters.
// R15: all external inputs pass two-stage synchronisers first; RESET is not synchronised and clears the flops asynchronously.
`ifndef SUPERVISOR_DEFINES_VH
`define SUPERVISOR_DEFINES_VH
`define CLK_FREQ_HZ      20000000
`define STRETCH_TIME_MS  200
`define WDOG_TIME_MS     1600
`define WRITE_TIME_NS    18000
`define CLK_PERIOD_NS    50
`define STRETCH_CYCLES   ((`STRETCH_TIME_MS * (`CLK_FREQ_HZ / 1000)))
`define WDOG_CYCLES      ((`WDOG_TIME_MS * (`CLK_FREQ_HZ / 1000)))
`define WRITE_CYCLES     (`WRITE_TIME_NS / `CLK_PERIOD_NS)
`endif

// *** hdl/input_sync.v ***
// two-flop synchroniser bank for asynchronous inputs
`timescale 1ns/1ns
`default_nettype none
module input_sync #(
  parameter WIDTH = 1
) (
  input  wire             clk,
  input  wire             rst,
  input  wire [WIDTH-1:0] async_in,
  input  wire [WIDTH-1:0] reset_value,
  output wire [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] stage1;
  reg [WIDTH-1:0] stage2;
  // stage1 only feeds stage2 to keep metastability contained
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          stage1[i] <= 1'b0;
          stage2[i] <= 1'b0;
        end else begin
          stage1[i] <= async_in[i];
          stage2[i] <= stage1[i];
        end
      end
    end
  endgenerate
  assign sync_out = stage2 ^ reset_value;
endmodule // input_sync
`default_nettype wire

// *** hdl/supply_supervisor_watchdog.v ***
// supply supervisor: reset stretch, watchdog, chip-select gating
`timescale 1ns/1ns
`default_nettype none
`include "supervisor_defines.vh"
module supply_supervisor_watchdog #(
  parameter STRETCH_CYCLES = `STRETCH_CYCLES,
  parameter WDOG_CYCLES    = `WDOG_CYCLES,
  parameter WRITE_CYCLES   = `WRITE_CYCLES
) (
  // clock and reset
  input  wire SYS_CLK,
  input  wire RESET,
  // comparator flags
  input  wire BELOW_TRIP,
  input  wire BELOW_WARNING,
  input  wire BELOW_BACKUP_CELL,
  // watchdog
  input  wire KICK_INPUT,
  input  wire KICK_FLOATING,
  // chip-select
  input  wire CS_IN_N,
  // outputs
  output reg  SYS_RESET_N,
  output reg  SYS_RESET,
  output reg  SUPPLY_WARNING_N,
  output reg  CS_OUT_N,
  output reg  RAM_FROM_BACKUP_CELL
);
  wire [5:0] raw;
  wire [5:0] syn;
  // sync value 0 maps to safe levels; chip-select input idles high
  assign raw = {CS_IN_N, KICK_FLOATING, KICK_INPUT,
                BELOW_BACKUP_CELL, BELOW_WARNING, BELOW_TRIP};
  input_sync #(.WIDTH(6)) u_sync (              // R15
    .clk         (SYS_CLK),
    .rst         (RESET),
    .async_in    (raw ^ 6'h20),
    .reset_value (6'h20),
    .sync_out    (syn)
  );
  wire below_trip    = syn[0];
  wire below_warning = syn[1];
  wire below_cell    = syn[2];
  wire kick          = syn[3];
  wire kick_floating = syn[4];
  wire cs_in_n       = syn[5];

  // limits held as 32-bit values so compares stay unsigned
  localparam [31:0] STRETCH_LAST = STRETCH_CYCLES - 1;
  localparam [31:0] WDOG_LAST    = WDOG_CYCLES - 1;
  localparam [31:0] WRITE_LAST   = WRITE_CYCLES - 1;

  // gate states: shut, passing, holding for a write to finish
  localparam [1:0] GATE_SHUT = 2'b00;
  localparam [1:0] GATE_PASS = 2'b01;
  localparam [1:0] GATE_HOLD = 2'b10;

  // 32-bit counters cover the full-length production intervals
  reg [31:0] stretch_count;
  reg [31:0] next_stretch_count;
  reg        stretching;
  reg        next_stretching;
  reg        wdog_expired;
  reg [31:0] wdog_count;
  reg [31:0] next_wdog_count;
  reg        kick_last;
  reg [1:0]  gate_state;
  reg [1:0]  next_gate_state;
  reg [31:0] write_count;
  reg [31:0] next_write_count;
  reg        next_sys_reset_n;
  reg        next_sys_reset;
  reg        next_supply_warning_n;
  reg        next_cs_out_n;
  reg        next_ram_from_backup_cell;

  // any of the three causes holds the system in reset
  wire reset_active = below_trip | stretching | wdog_expired;
  wire kick_edge    = (kick != kick_last);
  wire wdog_full    = (wdog_count >= WDOG_LAST);
  wire stretch_done = (stretch_count >= STRETCH_LAST);
  wire write_done   = (write_count >= WRITE_LAST);
  wire wdog_fire    = !kick_floating && !reset_active &&
                      wdog_full && !kick_edge;             // R5 R6
  wire gate_open    = (gate_state != GATE_SHUT);

  // reset stretch timer
  always @* begin
    next_stretch_count = stretch_count;
    next_stretching    = stretching;
    if (below_trip || wdog_fire) begin
      // a fresh dip or expiry always restarts the full stretch
      next_stretch_count = 32'h0;                        // R11 R4
      next_stretching    = 1'b1;                         // R2
    end else if (stretching) begin
      if (stretch_done) begin
        next_stretching = 1'b0;                          // R3
      end else begin
        next_stretch_count = stretch_count + 32'h1;      // R14
      end
    end
  end

  // power-up starts inside a stretch, as after a supply dip
  always @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      stretch_count <= 32'h0;
      stretching    <= 1'b1;
    end else begin
      stretch_count <= next_stretch_count;
      stretching    <= next_stretching;
    end
  end

  // one-cycle expiry pulse; the stretch has latched it already
  always @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      wdog_expired <= 1'b0;
    end else begin
      wdog_expired <= wdog_fire;
    end
  end

  // watchdog counter; cleared by edges and held during reset
  always @* begin
    next_wdog_count = wdog_count;
    if (reset_active || kick_floating || kick_edge) begin
      next_wdog_count = 32'h0;                           // R10 R6
    end else if (!wdog_full) begin
      next_wdog_count = wdog_count + 32'h1;              // R14
    end
  end

  always @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      wdog_count <= 32'h0;
      kick_last  <= 1'b0;
    end else begin
      wdog_count <= next_wdog_count;
      kick_last  <= kick;
    end
  end

  // chip-select gate with write completion window
  always @* begin
    next_gate_state  = gate_state;
    next_write_count = write_count;
    case (gate_state)
      GATE_SHUT: begin
        // reopen only when input seen low after reset ends
        if (!reset_active && !cs_in_n) begin
          next_gate_state = GATE_PASS;                   // R13
        end
      end
      GATE_PASS: begin
        if (reset_active) begin
          if (!cs_in_n) begin
            next_gate_state  = GATE_HOLD;                // R12
            next_write_count = 32'h0;
          end else begin
            next_gate_state = GATE_SHUT;                 // R12
          end
        end
      end
      GATE_HOLD: begin
        if (!reset_active) begin
          next_gate_state  = GATE_PASS;
          next_write_count = 32'h0;
        end else if (cs_in_n || write_done) begin
          next_gate_state = GATE_SHUT;                   // R12
        end else begin
          next_write_count = write_count + 32'h1;        // R14
        end
      end
      default: begin
        next_gate_state  = GATE_SHUT;
        next_write_count = 32'h0;
      end
    endcase
  end

  always @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      gate_state  <= GATE_SHUT;
      write_count <= 32'h0;
    end else begin
      gate_state  <= next_gate_state;
      write_count <= next_write_count;
    end
  end

  // output values, one register stage behind the synced inputs
  always @* begin
    next_sys_reset_n          = !reset_active;           // R2
    next_sys_reset            = reset_active;            // R7
    next_supply_warning_n     = !below_warning;          // R1
    next_cs_out_n             = gate_open ? cs_in_n : 1'b1; // R8
    next_ram_from_backup_cell = below_trip & below_cell; // R9
  end

  // registered outputs; reset shows the safe levels
  always @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      SYS_RESET_N          <= 1'b0;
      SYS_RESET            <= 1'b1;
      SUPPLY_WARNING_N     <= 1'b0;
      CS_OUT_N             <= 1'b1;
      RAM_FROM_BACKUP_CELL <= 1'b0;
    end else begin
      SYS_RESET_N          <= next_sys_reset_n;
      SYS_RESET            <= next_sys_reset;
      SUPPLY_WARNING_N     <= next_supply_warning_n;
      CS_OUT_N             <= next_cs_out_n;
      RAM_FROM_BACKUP_CELL <= next_ram_from_backup_cell;
    end
  end
endmodule // supply_supervisor_watchdog
`default_nettype wire

// *** test/supervisor_properties.sv ***
// port assertions for the supply supervisor
`timescale 1ns/1ns
`default_nettype none
module supervisor_properties (
  input wire logic SYS_CLK, RESET, BELOW_TRIP, BELOW_WARNING,
  input wire logic BELOW_BACKUP_CELL, KICK_FLOATING,
  input wire logic SYS_RESET_N, SYS_RESET, SUPPLY_WARNING_N,
  input wire logic CS_OUT_N, RAM_FROM_BACKUP_CELL
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RESET);
  inverse_out_a: assert property (SYS_RESET == !SYS_RESET_N)
    else $error("inverse broken");
  trip_hold_a: assert property (BELOW_TRIP[*4] |-> !SYS_RESET_N)
    else $error("reset not held");
  stretch_len_a: assert property ($rose(SYS_RESET_N) |->
    !$past(BELOW_TRIP, 18)) else $error("stretch short");
  warn_low_a: assert property (BELOW_WARNING[*4] |-> !SUPPLY_WARNING_N)
    else $error("no warning");
  backup_on_a: assert property ((BELOW_TRIP && BELOW_BACKUP_CELL)[*4]
    |-> RAM_FROM_BACKUP_CELL) else $error("no backup");
  cs_block_a: assert property ((!SYS_RESET_N)[*8] |-> CS_OUT_N)
    else $error("gate open");
  cs_hold_a: assert property (!SYS_RESET_N && CS_OUT_N ##1
    !SYS_RESET_N |-> CS_OUT_N) else $error("gate reopened");
  quiet_wdog_a: assert property ((KICK_FLOATING && !BELOW_TRIP)[*6]
    |-> !$fell(SYS_RESET_N)) else $error("watchdog fired");
endmodule // supervisor_properties
bind supply_supervisor_watchdog supervisor_properties props (.*);
`default_nettype wire

// *** test/kick_host.sv ***
// host side: toggles the kick input while enabled
`timescale 1ns/1ns
`default_nettype none
module kick_host (
  input  wire logic clk,
  input  wire logic en,
  output var  logic kick
);
  initial kick = 1'b0;
  // toggle each cycle, far inside the timeout
  always @(posedge clk) kick <= #5 en ? !kick : kick;
endmodule // kick_host
`default_nettype wire

// *** test/supply_supervisor_watchdog_tb_top.sv ***
// self-checking bench for the supply supervisor
`timescale 1ns/1ns
`default_nettype none
module supply_supervisor_watchdog_tb_top;
  logic SYS_CLK = 0, RESET = 1, BELOW_TRIP = 0, BELOW_WARNING = 0;
  logic BELOW_BACKUP_CELL = 0, KICK_FLOATING = 0, CS_IN_N = 1, en = 1;
  wire logic KICK_INPUT, SYS_RESET_N, SYS_RESET, SUPPLY_WARNING_N;
  wire logic CS_OUT_N, RAM_FROM_BACKUP_CELL;
  int error_cnt = 0, comparisons = 0;
  supply_supervisor_watchdog #(20, 50, 5) DUT (.*);
  kick_host host (.clk(SYS_CLK), .en(en), .kick(KICK_INPUT));
  task w(input int n);
    repeat (n) @(posedge SYS_CLK);
    #5;
  endtask
  task c(input logic got, exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task print_verdict;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task trip_scn;
    BELOW_TRIP = 1;
    w(6);
    c(SYS_RESET, 1);
    BELOW_TRIP = 0;
    w(10);
    BELOW_TRIP = 1;
    w(2);
    BELOW_TRIP = 0;
    w(18);
    c(SYS_RESET_N, 0);
    w(10);
    c(SYS_RESET_N, 1);
  endtask
  task wdog_scn;
    en = 0;
    w(45);
    c(SYS_RESET_N, 1);
    w(15);
    c(SYS_RESET_N, 0);
    en = 1;
    w(30);
    c(SYS_RESET_N, 1);
    KICK_FLOATING = 1;
    en = 0;
    w(120);
    c(SYS_RESET_N, 1);
    KICK_FLOATING = 0;
    en = 1;
  endtask
  task misc_scn;
    BELOW_WARNING = 1;
    BELOW_BACKUP_CELL = 1;
    CS_IN_N = 0;
    w(5);
    c(SUPPLY_WARNING_N, 0);
    c(RAM_FROM_BACKUP_CELL, 0);
    BELOW_TRIP = 1;
    w(5);
    c(RAM_FROM_BACKUP_CELL, 1);
    c(CS_OUT_N, 0);
    w(6);
    c(CS_OUT_N, 1);
    CS_IN_N = 1;
    w(3);
    CS_IN_N = 0;
    w(4);
    c(CS_OUT_N, 1);
    BELOW_TRIP = 0;
    w(30);
    c(CS_OUT_N, 0);
    BELOW_WARNING = 0;
    w(4);
    c(SUPPLY_WARNING_N, 1);
  endtask
  initial forever #25 SYS_CLK = !SYS_CLK;
  initial begin
    #100000;
    error_cnt++;
    print_verdict;
  end
  initial begin
    w(5);
    RESET = 0;
    w(10);
    c(SYS_RESET_N, 0);
    w(20);
    c(SYS_RESET_N, 1);
    trip_scn;
    wdog_scn;
    misc_scn;
    print_verdict;
  end
endmodule // supply_supervisor_watchdog_tb_top
`default_nettype wire
